// >>> pkg/wdhr_pkg.sv
/*
 * Shared constants and types of the halt-then-reset watchdog.
 * Assumes a 250 MHz system clock and 32-bit APB software access.
 */
package wdhr_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] WDHR_OFF_CTRL    = 12'h000;
	localparam logic [11:0] WDHR_OFF_TIMEOUT = 12'h004;
	localparam logic [11:0] WDHR_OFF_COUNT   = 12'h008;
	localparam logic [11:0] WDHR_OFF_REASON  = 12'h00C;
	localparam logic [11:0] WDHR_OFF_IRQSTAT = 12'h010;
	localparam logic [11:0] WDHR_OFF_IRQMASK = 12'h014;
	localparam logic [11:0] WDHR_OFF_STATUS  = 12'h018;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int WDHR_CTRL_EN_BIT     = 0;
	localparam int WDHR_EVT_EXPIRE_BIT  = 0;
	localparam int WDHR_EVT_RESET_BIT   = 1;
	localparam int WDHR_IRQ_W           = 2;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [2:0]  WDHR_CTRL_RST    = 3'h4;
	localparam logic [1:0]  WDHR_MASK_RST    = 2'h0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned WDHR_CLK_MHZ        = 250;
	localparam int unsigned WDHR_HALT_TO_RST_MS = 300;
	localparam int unsigned WDHR_HALT_TO_RST_CYC = WDHR_HALT_TO_RST_MS * 1000 * WDHR_CLK_MHZ;
	localparam logic [4:0]  WDHR_RST_PULSE_CYC  = 5'h10;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic rst_en;
		logic diag;
		logic enable;
	} wdhr_ctrl_t;

	typedef enum logic [3:0] {
		WDHR_ST_IDLE = 4'h1,
		WDHR_ST_RUN  = 4'h2,
		WDHR_ST_HALT = 4'h4,
		WDHR_ST_DONE = 4'h8
	} wdhr_state_t;

endpackage : wdhr_pkg

// >>> rtl/wdhr_top.sv
/*
 * Halt-then-reset watchdog with APB register access.
 * Assumes APB master on clk_sys_in; sys_rst_out is taken by board reset logic.
 */
// Overview of operation
// - Writing the timeout register in idle or run starts timing; elapse of that count means expiry.
// - On expiry the halt interrupt rises first, before any reset action.
// - About 300 ms after halt, system reset fires unless diagnostic bit is set or reset enable bit is clear.
// - Expiry records a watchdog cause in reset reason, diagnostic bit or not.
// - Indicator LED is off before expiry and on once expired.
// - Software can disable the timer and clear diagnostic bit; disabling stops timing.
// - Watchdog reset enable bit gates the hardware reset; zero means no reset.
`timescale 1ns/1ps
`default_nettype none

module wdhr_top
	import wdhr_pkg::*;
#(
	parameter int unsigned HALT_TO_RST_CYCLES = WDHR_HALT_TO_RST_CYC
)(
	input  wire logic        clk_sys_in,
	input  wire logic        sys_rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic             halt_irq_out,
	output logic             wdog_led_out,
	output logic             sys_rst_out,
	output logic             irq_out
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	wdhr_state_t         state_reg;
	wdhr_ctrl_t          ctrl_reg;
	logic [31:0]         tmo_reg;
	logic [31:0]         cnt_reg;
	logic [31:0]         grace_reg;
	logic                reason_reg;
	logic [WDHR_IRQ_W-1:0] irq_stat_reg;
	logic [WDHR_IRQ_W-1:0] irq_mask_reg;
	logic [WDHR_IRQ_W-1:0] evt;
	logic [4:0]          rst_cnt_reg;
	logic [31:0]         prdata_reg;
	logic                pready_reg;
	logic                pslverr_reg;
	logic                halt_reg;
	logic                led_reg;
	logic                sys_rst_reg;
	logic                irq_reg;
	logic                acc;
	logic                wr_acc;
	logic                rd_acc;
	logic                tmo_wr;
	logic                ctrl_wr;
	logic                dis_wr;
	logic                armable;
	logic                expire_evt;
	logic                grace_end;
	logic                reset_fire;
	logic                mapped;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	assign acc     = psel_in & penable_in & pready_reg;
	assign wr_acc  = acc & pwrite_in;
	assign rd_acc  = acc & ~pwrite_in;
	assign tmo_wr  = wr_acc & (paddr_in == WDHR_OFF_TIMEOUT);
	assign ctrl_wr = wr_acc & (paddr_in == WDHR_OFF_CTRL);
	assign dis_wr  = ctrl_wr & ~pwdata_in[WDHR_CTRL_EN_BIT];
	assign mapped  = (paddr_in == WDHR_OFF_CTRL) | (paddr_in == WDHR_OFF_TIMEOUT) |
	                 (paddr_in == WDHR_OFF_COUNT) | (paddr_in == WDHR_OFF_REASON) |
	                 (paddr_in == WDHR_OFF_IRQSTAT) | (paddr_in == WDHR_OFF_IRQMASK) |
	                 (paddr_in == WDHR_OFF_STATUS);

	// ------------------------------------------------------------
	// Watchdog events
	// ------------------------------------------------------------
	assign armable    = (state_reg == WDHR_ST_IDLE) | (state_reg == WDHR_ST_RUN);
	assign expire_evt = (state_reg == WDHR_ST_RUN) & ~dis_wr & ~tmo_wr & (cnt_reg <= 32'h00000001);
	assign grace_end  = (state_reg == WDHR_ST_HALT) & ~dis_wr &
	                    (grace_reg == 32'(HALT_TO_RST_CYCLES - 1));
	assign reset_fire = grace_end & ctrl_reg.rst_en & ~ctrl_reg.diag;
	assign evt        = {reset_fire, expire_evt};

	// ------------------------------------------------------------
	// Bus handshake and read data
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end
		else
		begin
			pready_reg  <= psel_in & penable_in & ~pready_reg;
			pslverr_reg <= psel_in & penable_in & ~pready_reg & ~mapped;
			prdata_reg  <= 32'h00000000;
			if (psel_in & penable_in & ~pready_reg & ~pwrite_in)
			begin
				case (paddr_in)
					WDHR_OFF_CTRL:    prdata_reg <= {29'h00000000, ctrl_reg};
					WDHR_OFF_TIMEOUT: prdata_reg <= tmo_reg;
					WDHR_OFF_COUNT:   prdata_reg <= cnt_reg;
					WDHR_OFF_REASON:  prdata_reg <= {31'h00000000, reason_reg};
					WDHR_OFF_IRQSTAT: prdata_reg <= {30'h00000000, irq_stat_reg};
					WDHR_OFF_IRQMASK: prdata_reg <= {30'h00000000, irq_mask_reg};
					WDHR_OFF_STATUS:  prdata_reg <= {28'h0000000, state_reg};
					default:          prdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Control and timeout registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			ctrl_reg     <= WDHR_CTRL_RST;
			tmo_reg      <= 32'h00000000;
			irq_mask_reg <= WDHR_MASK_RST;
		end
		else
		begin
			if (ctrl_wr)
				ctrl_reg <= pwdata_in[2:0];
			else if (tmo_wr & armable)
				ctrl_reg.enable <= 1'b1;
			if (tmo_wr)
				tmo_reg <= pwdata_in;
			if (wr_acc & (paddr_in == WDHR_OFF_IRQMASK))
				irq_mask_reg <= pwdata_in[WDHR_IRQ_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			state_reg <= WDHR_ST_IDLE;
		else
		begin
			case (state_reg)
				WDHR_ST_IDLE:
					if (tmo_wr)
						state_reg <= WDHR_ST_RUN;
				WDHR_ST_RUN:
					if (dis_wr)
						state_reg <= WDHR_ST_IDLE;
					else if (expire_evt)
						state_reg <= WDHR_ST_HALT;
				WDHR_ST_HALT:
					if (dis_wr)
						state_reg <= WDHR_ST_IDLE;
					else if (grace_end)
						state_reg <= WDHR_ST_DONE;
				WDHR_ST_DONE:
					if (dis_wr)
						state_reg <= WDHR_ST_IDLE;
				default:
					state_reg <= WDHR_ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			cnt_reg <= 32'h00000000;
		else if (tmo_wr & armable)
			cnt_reg <= (pwdata_in == 32'h00000000) ? 32'h00000001 : pwdata_in;
		else if ((state_reg == WDHR_ST_RUN) & ~dis_wr & (cnt_reg != 32'h00000000))
			cnt_reg <= cnt_reg - 32'h00000001;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in | (state_reg != WDHR_ST_HALT))
			grace_reg <= 32'h00000000;
		else
			grace_reg <= grace_reg + 32'h00000001;
	end

	// ------------------------------------------------------------
	// Halt, LED, reason and reset outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			halt_reg <= 1'b0;
			led_reg  <= 1'b0;
		end
		else if (dis_wr)
		begin
			halt_reg <= 1'b0;
			led_reg  <= 1'b0;
		end
		else if (expire_evt)
		begin
			halt_reg <= 1'b1;
			led_reg  <= 1'b1;
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			reason_reg <= 1'b0;
		else if (expire_evt)
			reason_reg <= 1'b1;
		else if (wr_acc & (paddr_in == WDHR_OFF_REASON) & pwdata_in[0])
			reason_reg <= 1'b0;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			sys_rst_reg <= 1'b0;
			rst_cnt_reg <= 5'h00;
		end
		else if (reset_fire)
		begin
			sys_rst_reg <= 1'b1;
			rst_cnt_reg <= WDHR_RST_PULSE_CYC - 5'h01;
		end
		else if (rst_cnt_reg != 5'h00)
			rst_cnt_reg <= rst_cnt_reg - 5'h01;
		else
			sys_rst_reg <= 1'b0;
	end

	// ------------------------------------------------------------
	// Interrupt status, cleared by read, set wins
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			irq_stat_reg <= 2'h0;
			irq_reg      <= 1'b0;
		end
		else
		begin
			if (rd_acc & (paddr_in == WDHR_OFF_IRQSTAT))
				irq_stat_reg <= evt;
			else
				irq_stat_reg <= irq_stat_reg | evt;
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	assign prdata_out   = prdata_reg;
	assign pready_out   = pready_reg;
	assign pslverr_out  = pslverr_reg;
	assign halt_irq_out = halt_reg;
	assign wdog_led_out = led_reg;
	assign sys_rst_out  = sys_rst_reg;
	assign irq_out      = irq_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	a_timeout_arm_load: assert property ((tmo_wr && state_reg == WDHR_ST_IDLE && pwdata_in > 32'h1) |=>
		(state_reg == WDHR_ST_RUN) && (cnt_reg == $past(pwdata_in)))
		else $error("timeout write did not start timing");
	a_halt_before_reset: assert property ($rose(halt_reg) |-> !sys_rst_reg && ($past(state_reg) == WDHR_ST_RUN))
		else $error("halt not raised first on expiry");
	a_reset_after_grace: assert property ($rose(sys_rst_reg) |->
		($past(state_reg) == WDHR_ST_HALT) && !$past(ctrl_reg.diag) && halt_reg)
		else $error("reset without grace or with diagnostic set");
	a_reset_pulse_width: assert property ($rose(sys_rst_reg) |-> sys_rst_reg [*8])
		else $error("reset pulse too short");
	a_reason_on_expiry: assert property ($rose(halt_reg) |-> reason_reg)
		else $error("reason not recorded on expiry");
	a_led_tracks_expiry: assert property ((state_reg == WDHR_ST_RUN || state_reg == WDHR_ST_IDLE) |->
		!led_reg && !halt_reg)
		else $error("LED on before expiry");
	a_disable_stops: assert property (dis_wr |=> state_reg == WDHR_ST_IDLE ##1 state_reg != WDHR_ST_HALT)
		else $error("disable did not stop timing");
	a_reset_enable_gate: assert property ($rose(sys_rst_reg) |-> $past(ctrl_reg.rst_en))
		else $error("reset issued while reset enable clear");

endmodule : wdhr_top

`default_nettype wire

// >>> tb/wdhr_top_test.sv
/*
 * Self-checking bench of the halt-then-reset watchdog, driven over APB.
 * Assumes wdhr_pkg and wdhr_top are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module wdhr_top_test import wdhr_pkg::*;;

	localparam int HC = 20;

	logic        clk_sys_in;
	logic        sys_rst_in;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        halt_irq;
	logic        led;
	logic        sys_rst;
	logic        irq;
	int          n_fail;
	int          n_tests;

	wdhr_top #(.HALT_TO_RST_CYCLES(HC)) uut (
		.clk_sys_in   (clk_sys_in),
		.sys_rst_in   (sys_rst_in),
		.psel_in      (psel),
		.penable_in   (penable),
		.pwrite_in    (pwrite),
		.paddr_in     (paddr),
		.pwdata_in    (pwdata),
		.prdata_out   (prdata),
		.pready_out   (pready),
		.pslverr_out  (pslverr),
		.halt_irq_out (halt_irq),
		.wdog_led_out (led),
		.sys_rst_out  (sys_rst),
		.irq_out      (irq)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task give_verdict;
		$display("Checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys_in);
		penable <= 1'h1;
		do
		begin
			@(posedge clk_sys_in);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task rchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		chk(nm, ex, rd);
	endtask : rchk

	task cycles(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : cycles

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		rchk("ctrl", WDHR_OFF_CTRL, 32'h4);
		rchk("mask", WDHR_OFF_IRQMASK, 32'h0);
		rchk("state", WDHR_OFF_STATUS, 32'h1);
		chk("outs", 32'h0, {28'h0, halt_irq, led, sys_rst, irq});
		rchk("unmapped", 12'h0FC, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
	endtask : t_reset

	task t_expire(input logic [31:0] ctrl, input logic [1:0] mask, input logic rst_exp);
		int c;
		apb(1'b1, WDHR_OFF_CTRL, ctrl);
		apb(1'b1, WDHR_OFF_IRQMASK, {30'h0, mask});
		apb(1'b1, WDHR_OFF_TIMEOUT, 32'hA);
		c = 0;
		chk("led early", 32'h0, {31'h0, led});
		while (halt_irq !== 1'b1 && c < 300)
		begin
			cycles(1);
			c++;
		end
		chk("expiry cycles", 32'hA, c);
		chk("reset before halt", 32'h0, {31'h0, sys_rst});
		chk("led on", 32'h1, {31'h0, led});
		cycles(2);
		chk("irq", {31'h0, mask[0]}, {31'h0, irq});
		c = 2;
		while (sys_rst !== 1'b1 && c < HC + 30)
		begin
			cycles(1);
			c++;
		end
		chk("reset issued", {31'h0, rst_exp}, {31'h0, sys_rst});
		if (rst_exp)
		begin
			chk("grace", 32'h1, {31'h0, (c >= HC && c <= HC + 1)});
			c = 0;
			while (sys_rst === 1'b1 && c < 40)
			begin
				cycles(1);
				c++;
			end
			chk("pulse", 32'h10, c);
		end
		rchk("irqstat", WDHR_OFF_IRQSTAT, {30'h0, rst_exp, 1'b1});
		rchk("irqstat cleared", WDHR_OFF_IRQSTAT, 32'h0);
		rchk("count spent", WDHR_OFF_COUNT, 32'h0);
		rchk("reason", WDHR_OFF_REASON, 32'h1);
		apb(1'b1, WDHR_OFF_CTRL, 32'h4);
		cycles(2);
		chk("halt off", 32'h0, {30'h0, halt_irq, led});
		chk("irq off", 32'h0, {31'h0, irq});
		rchk("ctrl off", WDHR_OFF_CTRL, 32'h4);
		apb(1'b1, WDHR_OFF_REASON, 32'h1);
		rchk("reason clr", WDHR_OFF_REASON, 32'h0);
	endtask : t_expire

	task t_disable;
		apb(1'b1, WDHR_OFF_TIMEOUT, 32'h1E);
		cycles(20);
		apb(1'b1, WDHR_OFF_TIMEOUT, 32'h1E);
		cycles(20);
		chk("kick", 32'h0, {31'h0, halt_irq});
		apb(1'b1, WDHR_OFF_CTRL, 32'h4);
		cycles(40);
		chk("stopped", 32'h0, {31'h0, halt_irq});
		rchk("idle", WDHR_OFF_STATUS, 32'h1);
		rchk("no event", WDHR_OFF_IRQSTAT, 32'h0);
	endtask : t_disable

	// ------------------------------------------------------------
	// Clock, reset, sequence, watchdog
	// ------------------------------------------------------------
	initial
	begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	initial
	begin
		n_fail = 0;
		n_tests = 0;
		sys_rst_in = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (8) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_expire(32'h4, 2'h3, 1'b1);
		t_expire(32'h6, 2'h0, 1'b0);
		t_expire(32'h0, 2'h1, 1'b0);
		t_disable();
		give_verdict();
	end

	initial
	begin
		#200000;
		n_fail++;
		give_verdict();
	end

endmodule : wdhr_top_test

`default_nettype wire
